// ### hdl/bble_cpu_end.sv
// Contract
// - Request and sequential flags lead by one cycle
// - Cycle ends only on edge with stretch high
// - Controller samples request only while stretch high
// - Fast clock: controller samples as late as possible
// - Slow clock: controller may sample earlier
// - Controller derives stretch from previous request
// - Endianness chosen by one control bit
// - Little-endian: byte 0 on lines 7..0
// - Big-endian: byte 0 on lines 31..24
// - Endianness touches only loads and stores
// - Word uses all lines; memory ignores a[1:0]
// - Byte store replicates low byte to lanes
// - Little-endian byte load picks lane, zero-extends
// - Big-endian byte load picks reversed lane, zero-extends
// - Processor rotates; memory only enables bytes
// - Memory may return full word on byte read
// - Four active-low byte lane selects driven
// - Lane selects combinational from a[1:0], width
// - Word 0000; bytes 1110,1101,1011,0111
// - Lane bits map to data bytes per endianness
module bble_cpu_end (
  input  wire logic        core_clk,   // Bus clock
  input  wire logic        srst,       // Synchronous reset, active high
  bble_bus_if.cpu          bus,        // Memory bus
  input  wire logic        req_valid,  // Transfer request
  output logic             req_ready,  // Request taken this edge
  input  wire logic        req_write,  // 1 store, 0 load
  input  wire logic        req_byte,   // Byte width, load/store only
  input  wire logic        req_ldst,   // Load/store, else plain word read or write
  input  wire logic [2:0]  req_beats,  // Sequential words, 0 counts as 1
  input  wire logic [31:0] req_addr,   // Start address
  input  wire logic [31:0] req_wdata,  // Store data, one value per beat
  input  wire logic        bigend,     // Endianness control bit
  output logic             beat_take,  // req_wdata taken this edge
  output logic             rsp_valid,  // Load result pulse
  output logic [31:0]      rsp_rdata,  // Load result
  output logic             busy        // Transfer in progress
);

  // ****************************************************************
  // State
  // ****************************************************************
  // One struct holds all state; the next value is built below
  typedef struct packed {
    // Transfer in flight
    bble_pkg::bble_dev_st_t st;
    logic [31:0]            addr;
    logic                   write;
    logic                   byte_op;
    logic                   big;
    logic [2:0]             left;
    // Cycle type, one cycle ahead
    logic                   mreq_n;
    logic                   sequential;
    // Data path
    logic [31:0]            wdata;
    logic                   d_oe;
    logic                   rsp_valid;
    logic [31:0]            rdata;
  } bble_dev_state_t;

  bble_dev_state_t s_q;
  bble_dev_state_t s_d;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Pick a byte lane from the data bus and zero-extend it
  // The three other lanes are ignored on a byte load
  function automatic logic [31:0] bble_load_byte(input logic [31:0] d, input logic [1:0] off, input logic big);
    logic [1:0] lane;
    lane = big ? ~off : off;
    return {24'h00_0000, d[{lane, 3'b000} +: 8]};
  endfunction : bble_load_byte

  // Beats remaining after the first, bytes always single
  // A beat count of zero still moves one word
  function automatic logic [2:0] bble_first_left(input logic [2:0] beats, input logic byte_op);
    return (byte_op || (beats == 3'h0)) ? 3'h0 : beats - 3'h1;
  endfunction : bble_first_left

  // Store data as it leaves: bytes go out on all four lanes
  // Replication lets the memory enable one lane, no shifter
  function automatic logic [31:0] bble_store_data(input logic [31:0] w, input logic byte_op);
    return byte_op ? {4{w[7:0]}} : w;
  endfunction : bble_store_data

  // ****************************************************************
  // Next state
  // ****************************************************************
  // The bus is held still whenever the memory stretches a data cycle
  // One idle cycle between transfers keeps the decode small
  always_comb begin
    // Defaults: state held, pulses low
    s_d           = s_q;
    s_d.rsp_valid = 1'b0;
    req_ready     = 1'b0;
    beat_take     = 1'b0;
    unique case (s_q.st)
      bble_pkg::DEV_IDLE: begin
        // Address and controls go out with the request announcement
        req_ready = 1'b1;
        if (req_valid) begin
          s_d.addr    = req_addr;
          s_d.write   = req_write;
          s_d.byte_op = req_byte & req_ldst;
          // Latched, so the bit may change mid-transfer
          s_d.big     = bigend;
          s_d.left    = bble_first_left(req_beats, req_byte & req_ldst);
          s_d.mreq_n     = 1'b0;
          s_d.sequential = 1'b0;
          s_d.st      = bble_pkg::DEV_ANN;
        end
      end
      bble_pkg::DEV_ANN: begin
        // First data cycle starts; announce whether another follows
        s_d.st     = bble_pkg::DEV_DATA;
        s_d.d_oe   = s_q.write;
        s_d.mreq_n = (s_q.left == 3'h0);
        s_d.sequential = (s_q.left != 3'h0);
        // First store word is taken a cycle before it drives
        if (s_q.write) begin
          beat_take = 1'b1;
          s_d.wdata = bble_store_data(req_wdata, s_q.byte_op);
        end
      end
      bble_pkg::DEV_DATA: begin
        // Cycle boundary only when stretch is released
        if (bus.cycle_stretch_n) begin
          if (!s_q.write) begin
            s_d.rsp_valid = 1'b1;
            // Word loads use all lines unchanged; bytes are rotated here
            s_d.rdata = s_q.byte_op ? bble_load_byte(bus.d_bus, s_q.addr[1:0], s_q.big)
                                    : bus.d_bus;
          end
          // More beats: step the address, announce the next
          if (s_q.left != 3'h0) begin
            s_d.addr       = s_q.addr + bble_pkg::ADDR_STEP;
            s_d.left       = s_q.left - 3'h1;
            s_d.mreq_n     = (s_q.left == 3'h1);
            s_d.sequential = (s_q.left != 3'h1);
            if (s_q.write) begin
              beat_take = 1'b1;
              s_d.wdata = bble_store_data(req_wdata, s_q.byte_op);
            end
          end else begin
            // Address and width stay at their last value while idle
            s_d.st     = bble_pkg::DEV_IDLE;
            s_d.mreq_n = bble_pkg::RST_MREQ_N;
            s_d.sequential = bble_pkg::RST_SEQUENTIAL;
            s_d.d_oe   = 1'b0;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Register
  // ****************************************************************
  // Synchronous reset only; no asynchronous path
  always_ff @(posedge core_clk) begin
    if (srst) begin
      // Idle bus levels; address parks at zero
      s_q.st        <= bble_pkg::DEV_IDLE;
      s_q.addr      <= 32'h0000_0000;
      s_q.write     <= 1'b0;
      s_q.byte_op   <= 1'b0;
      s_q.big       <= 1'b0;
      s_q.left      <= 3'h0;
      s_q.mreq_n    <= bble_pkg::RST_MREQ_N;
      s_q.sequential <= bble_pkg::RST_SEQUENTIAL;
      s_q.wdata     <= 32'h0000_0000;
      s_q.d_oe      <= 1'b0;
      s_q.rsp_valid <= 1'b0;
      s_q.rdata     <= 32'h0000_0000;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Bus outputs
  // ****************************************************************
  // Pipelined cycle type straight from flops, so no glitch reaches memory
  assign bus.memory_request_n      = s_q.mreq_n;
  assign bus.sequential_cycle_flag = s_q.sequential;
  // Address, direction and width park after a transfer
  assign bus.addr                  = s_q.addr;
  assign bus.read_not_write        = s_q.write;
  assign bus.byte_not_word         = ~s_q.byte_op;

  // Lane selects follow the address with no extra flop stage
  assign bus.byte_lane_select_n = bble_pkg::bble_lane_sel(~s_q.byte_op, s_q.addr[1:0]);

  // Store data only while writing, so reads never contend
  assign bus.cpu_d_out = s_q.wdata;
  assign bus.cpu_d_oe  = s_q.d_oe;

  // ****************************************************************
  // User outputs
  // ****************************************************************
  // Result pulses one cycle; data holds until the next load
  assign rsp_valid = s_q.rsp_valid;
  assign rsp_rdata = s_q.rdata;

  // Busy spans the announce and the data cycles
  assign busy      = (s_q.st != bble_pkg::DEV_IDLE);

endmodule : bble_cpu_end

// ### hdl/bble_pkg.sv
package bble_pkg;

  // ****************************************************************
  // Widths and fixed codes
  // ****************************************************************
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned ADDR_W  = 32;
  localparam int unsigned BEATS_W = 3;

  // Active-low lane selects: word, then byte at offsets 0..3
  localparam logic [3:0] LANES_WORD = 4'h0;
  localparam logic [3:0] LANES_B0   = 4'he;
  localparam logic [3:0] LANES_B1   = 4'hd;
  localparam logic [3:0] LANES_B2   = 4'hb;
  localparam logic [3:0] LANES_B3   = 4'h7;

  localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0004;

  // Reset levels of the bus outputs
  localparam logic RST_MREQ_N     = 1'b1;
  localparam logic RST_SEQUENTIAL = 1'b0;

  // Default controller timing and depth
  localparam int unsigned WAIT_STATES_DEF = 1;
  localparam int unsigned DEPTH_DEF       = 1024;

  // ****************************************************************
  // State types
  // ****************************************************************
  typedef enum logic [2:0] {
    DEV_IDLE = 3'b001,
    DEV_ANN  = 3'b010,
    DEV_DATA = 3'b100
  } bble_dev_st_t;

  typedef enum logic [1:0] {
    MEM_IDLE = 2'b01,
    MEM_DATA = 2'b10
  } bble_mem_st_t;

  // ****************************************************************
  // Shared decode
  // ****************************************************************
  // Lane select from width and low address bits, same for both endians
  function automatic logic [3:0] bble_lane_sel(input logic byte_not_word, input logic [1:0] a);
    logic [3:0] r;
    r = LANES_WORD;
    if (!byte_not_word) begin
      unique case (a)
        2'h0: r = LANES_B0;
        2'h1: r = LANES_B1;
        2'h2: r = LANES_B2;
        2'h3: r = LANES_B3;
      endcase
    end
    return r;
  endfunction : bble_lane_sel

  // Active-low lane selects to active-high data byte enables
  function automatic logic [3:0] bble_byte_en(input logic [3:0] lanes_n, input logic big);
    logic [3:0] e;
    e = ~lanes_n;
    return big ? {e[0], e[1], e[2], e[3]} : e;
  endfunction : bble_byte_en

endpackage : bble_pkg

// ### hdl/bble_bus_if.sv
interface bble_bus_if;

  // ****************************************************************
  // Bus wires
  // ****************************************************************
  logic [31:0] addr;                  // Address, pipelined
  logic        memory_request_n;      // Next cycle is a data cycle when low
  logic        sequential_cycle_flag; // Next data cycle is sequential
  logic        cycle_stretch_n;       // Low stretches the current cycle
  logic [3:0]  byte_lane_select_n;    // Active-low byte lane selects
  logic        read_not_write;        // Low read, high write
  logic        byte_not_word;         // Low byte, high word
  logic [31:0] cpu_d_out;             // Processor drive value
  logic        cpu_d_oe;              // Processor drives data
  logic [31:0] mem_d_out;             // Memory drive value
  logic        mem_d_oe;              // Memory drives data
  logic [31:0] d_bus;                 // Resolved data lines

  // Resolved level; an undriven bus reads as zero
  assign d_bus = cpu_d_oe ? cpu_d_out : (mem_d_oe ? mem_d_out : 32'h0000_0000);

  modport cpu (
    output addr, memory_request_n, sequential_cycle_flag, byte_lane_select_n,
    output read_not_write, byte_not_word, cpu_d_out, cpu_d_oe,
    input  cycle_stretch_n, d_bus
  );

  modport mem (
    input  addr, memory_request_n, sequential_cycle_flag, byte_lane_select_n,
    input  read_not_write, byte_not_word, d_bus,
    output cycle_stretch_n, mem_d_out, mem_d_oe
  );

endinterface : bble_bus_if

// ### hdl/bble_mem_end.sv
module bble_mem_end #(
  parameter int unsigned DEPTH        = bble_pkg::DEPTH_DEF,       // Words of memory
  parameter int unsigned WAIT_STATES  = bble_pkg::WAIT_STATES_DEF, // Stretch cycles per access
  parameter bit          EARLY_SAMPLE = 1'b0                       // Take store data early
) (
  input  wire logic        core_clk,     // Bus clock
  input  wire logic        srst,         // Synchronous reset, active high
  bble_bus_if.mem          bus,          // Memory bus
  input  wire logic        bigend,       // Lane wiring of this memory
  output logic             wr_done,      // Store completed pulse
  output logic [31:0]      wr_word_addr, // Word index of last store
  output logic [3:0]       wr_byte_en,   // Data bytes written by last store
  output logic             busy          // Data cycle in progress
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    bble_pkg::bble_mem_st_t st;
    logic [31:0]            addr;
    logic                   write;
    logic [3:0]             lanes_n;
    logic [7:0]             cnt;
    logic [31:0]            rdata;
    logic                   d_oe;
    logic [31:0]            wbuf;
    logic                   wr_done;
    logic [31:0]            wr_addr;
    logic [3:0]             wr_en;
  } bble_mem_state_t;

  bble_mem_state_t s_q;
  bble_mem_state_t s_d;
  logic [31:0]     mem_q [DEPTH];
  logic            we;
  logic [AW-1:0]   we_idx;
  logic [3:0]      we_en;
  logic [31:0]     we_data;
  logic [31:0]     nxt_addr;

  // Word index; low address bits never select within the array
  function automatic logic [AW-1:0] bble_widx(input logic [31:0] a);
    return a[AW+1:2];
  endfunction : bble_widx

  // ****************************************************************
  // Stretch and next state
  // ****************************************************************
  // Stretch comes from the current data cycle, not a cycle ahead
  assign bus.cycle_stretch_n = !((s_q.st == bble_pkg::MEM_DATA) && (s_q.cnt != 8'h00));

  // Sequential beats advance locally; the bus address still shows the current beat
  assign nxt_addr = bus.sequential_cycle_flag ? s_q.addr + bble_pkg::ADDR_STEP : bus.addr;

  always_comb begin
    s_d         = s_q;
    s_d.wr_done = 1'b0;
    we          = 1'b0;
    we_idx      = bble_widx(s_q.addr);
    we_en       = bble_pkg::bble_byte_en(s_q.lanes_n, bigend);
    // Late sampling takes store data on the ending edge
    we_data     = (EARLY_SAMPLE && (WAIT_STATES != 0)) ? s_q.wbuf : bus.d_bus;
    unique case (s_q.st)
      bble_pkg::MEM_IDLE: begin
        // Stretch is high here, so request is read on a boundary
        if (!bus.memory_request_n) begin
          s_d.st      = bble_pkg::MEM_DATA;
          s_d.addr    = bus.addr;
          s_d.write   = bus.read_not_write;
          s_d.lanes_n = bus.byte_lane_select_n;
          s_d.cnt     = 8'(WAIT_STATES);
          s_d.rdata   = mem_q[bble_widx(bus.addr)];
          s_d.d_oe    = !bus.read_not_write;
        end
      end
      bble_pkg::MEM_DATA: begin
        if (s_q.cnt != 8'h00) begin
          s_d.cnt = s_q.cnt - 8'h01;
          if (EARLY_SAMPLE && (s_q.cnt == 8'(WAIT_STATES))) begin
            s_d.wbuf = bus.d_bus;
          end
        end else begin
          if (s_q.write) begin
            // Enable only the selected bytes; no shifting of data
            we          = 1'b1;
            s_d.wr_done = 1'b1;
            s_d.wr_addr = 32'(we_idx);
            s_d.wr_en   = we_en;
          end
          if (!bus.memory_request_n) begin
            s_d.addr    = nxt_addr;
            s_d.write   = bus.read_not_write;
            s_d.lanes_n = bus.byte_lane_select_n;
            s_d.cnt     = 8'(WAIT_STATES);
            s_d.rdata   = mem_q[bble_widx(nxt_addr)];
            s_d.d_oe    = !bus.read_not_write;
          end else begin
            s_d.st   = bble_pkg::MEM_IDLE;
            s_d.d_oe = 1'b0;
          end
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers and array
  // ****************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      s_q.st      <= bble_pkg::MEM_IDLE;
      s_q.addr    <= 32'h0000_0000;
      s_q.write   <= 1'b0;
      s_q.lanes_n <= bble_pkg::LANES_WORD;
      s_q.cnt     <= 8'h00;
      s_q.rdata   <= 32'h0000_0000;
      s_q.d_oe    <= 1'b0;
      s_q.wbuf    <= 32'h0000_0000;
      s_q.wr_done <= 1'b0;
      s_q.wr_addr <= 32'h0000_0000;
      s_q.wr_en   <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge core_clk) begin
    for (int b = 0; b < 4; b++) begin
      if (we && we_en[b]) begin
        mem_q[we_idx][b*8 +: 8] <= we_data[b*8 +: 8];
      end
    end
  end

  // Full word driven on reads, so no lane floats
  assign bus.mem_d_out = s_q.rdata;
  assign bus.mem_d_oe  = s_q.d_oe;
  assign wr_done       = s_q.wr_done;
  assign wr_word_addr  = s_q.wr_addr;
  assign wr_byte_en    = s_q.wr_en;
  assign busy          = (s_q.st == bble_pkg::MEM_DATA);

endmodule : bble_mem_end

// ### verif/bble_bus_sva.sv
module bble_bus_sva (
  input wire logic        core_clk,              // Clock
  input wire logic        srst,                  // Reset
  input wire logic [31:0] addr,                  // Address
  input wire logic        memory_request_n,      // Request
  input wire logic        sequential_cycle_flag, // Sequential
  input wire logic        cycle_stretch_n,       // Stretch
  input wire logic [3:0]  byte_lane_select_n,    // Lanes
  input wire logic        read_not_write,        // Direction
  input wire logic        byte_not_word,         // Width
  input wire logic [31:0] cpu_d_out,             // Write data
  input wire logic        cpu_d_oe,              // Cpu drives
  input wire logic        mem_d_oe               // Mem drives
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // ********
  // Lane decode and data lanes
  // ********
  lanes_word_a: assert property (byte_not_word |-> byte_lane_select_n == 4'h0)
    else $error("word lane select wrong");
  lanes_byte_a: assert property (!byte_not_word |-> byte_lane_select_n == ~(4'h1 << addr[1:0]))
    else $error("byte lane select wrong");
  byte_repl_a: assert property (cpu_d_oe && !byte_not_word |-> cpu_d_out == {4{cpu_d_out[7:0]}})
    else $error("byte store not replicated");
  // Only one end may drive, and only in its own direction
  cpu_dir_a: assert property (cpu_d_oe |-> read_not_write && !mem_d_oe)
    else $error("processor drives on a read");
  mem_dir_a: assert property (mem_d_oe |-> !read_not_write)
    else $error("memory drives on a write");

  // ********
  // Cycle timing
  // ********
  req_ahead_a: assert property (!memory_request_n && cycle_stretch_n |=> cpu_d_oe || mem_d_oe)
    else $error("announced data cycle missing");
  hold_stretch_a: assert property (!cycle_stretch_n |=> $stable(addr) && $stable(byte_lane_select_n)
    && $stable({read_not_write, byte_not_word}))
    else $error("outputs moved while stretched");
  // Bench runs one wait state, so a stretch lasts one cycle
  stretch_len_a: assert property ($fell(cycle_stretch_n) |=> cycle_stretch_n)
    else $error("stretch too long");
  stretch_data_a: assert property (!cycle_stretch_n |-> cpu_d_oe || mem_d_oe)
    else $error("stretch outside data cycle");
  reset_idle_a: assert property (disable iff (1'b0) srst |=> memory_request_n && !sequential_cycle_flag)
    else $error("bus not idle after reset");

  cover property (cpu_d_oe && !byte_not_word);
  cover property (mem_d_oe && !byte_not_word);
  cover property (!memory_request_n && sequential_cycle_flag);
  cover property ($fell(cycle_stretch_n));
endmodule : bble_bus_sva

// ### verif/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk;
  logic        srst;
  logic        bigend;
  logic        req_valid;
  logic        req_ready;
  logic        req_write;
  logic        req_byte;
  logic        req_ldst;
  logic [2:0]  req_beats;
  logic [31:0] req_addr;
  logic [31:0] req_wdata;
  logic        beat_take;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic        cpu_busy;
  logic        wr_done;
  logic [31:0] wr_word_addr;
  logic [3:0]  wr_byte_en;
  logic        mem_busy;
  logic        rsp_valid_e;
  logic [31:0] rsp_rdata_e;
  logic [31:0] exp_mem [64];
  logic [31:0] rd_q [$];
  logic [31:0] rd_e_q [$];
  logic [35:0] wr_q [$];
  int          error_cnt;
  int          checks;
  int          e;
  int          o;

  bble_bus_if bus_if ();

  bble_cpu_end i_bble_cpu_end (
    .core_clk(core_clk), .srst(srst), .bus(bus_if.cpu), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_byte(req_byte), .req_ldst(req_ldst), .req_beats(req_beats),
    .req_addr(req_addr), .req_wdata(req_wdata), .bigend(bigend), .beat_take(beat_take),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .busy(cpu_busy)
  );

  // Small memory keeps the model short; one stretch cycle per access
  bble_mem_end #(.DEPTH(64), .WAIT_STATES(1), .EARLY_SAMPLE(1'b0)) i_bble_mem_end (
    .core_clk(core_clk), .srst(srst), .bus(bus_if.mem), .bigend(bigend), .wr_done(wr_done),
    .wr_word_addr(wr_word_addr), .wr_byte_en(wr_byte_en), .busy(mem_busy)
  );

  // Early-sampling twin pair, driven alike and checked against the same model
  bble_bus_if bus_e_if ();
  bble_cpu_end i_bble_cpu_end_e (
    .core_clk(core_clk), .srst(srst), .bus(bus_e_if.cpu), .req_valid(req_valid), .req_ready(),
    .req_write(req_write), .req_byte(req_byte), .req_ldst(req_ldst), .req_beats(req_beats),
    .req_addr(req_addr), .req_wdata(req_wdata), .bigend(bigend), .beat_take(),
    .rsp_valid(rsp_valid_e), .rsp_rdata(rsp_rdata_e), .busy()
  );
  bble_mem_end #(.DEPTH(64), .WAIT_STATES(1), .EARLY_SAMPLE(1'b1)) i_bble_mem_end_e (
    .core_clk(core_clk), .srst(srst), .bus(bus_e_if.mem), .bigend(bigend), .wr_done(),
    .wr_word_addr(), .wr_byte_en(), .busy()
  );

  bble_bus_sva i_bble_bus_sva (
    .core_clk(core_clk), .srst(srst), .addr(bus_if.addr), .memory_request_n(bus_if.memory_request_n),
    .sequential_cycle_flag(bus_if.sequential_cycle_flag), .cycle_stretch_n(bus_if.cycle_stretch_n),
    .byte_lane_select_n(bus_if.byte_lane_select_n), .read_not_write(bus_if.read_not_write),
    .byte_not_word(bus_if.byte_not_word), .cpu_d_out(bus_if.cpu_d_out), .cpu_d_oe(bus_if.cpu_d_oe),
    .mem_d_oe(bus_if.mem_d_oe)
  );

  // Clock, 4 ns period
  always #2 core_clk = ~core_clk;

  // Collect load results and completed stores as they pulse
  always @(posedge core_clk) begin
    if (rsp_valid === 1'b1) rd_q.push_back(rsp_rdata);
    if (wr_done === 1'b1) wr_q.push_back({wr_byte_en, wr_word_addr});
    if (rsp_valid_e === 1'b1) rd_e_q.push_back(rsp_rdata_e);
  end

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One transfer; returns once both ends are quiet again
  task automatic xfer(input logic wr, input logic by, input logic ls, input logic [2:0] n,
                      input logic [31:0] a, input logic [31:0] wd);
    int k;
    int t;
    req_valid <= 1'b1;
    req_write <= wr;
    req_byte  <= by;
    req_ldst  <= ls;
    req_beats <= n;
    req_addr  <= a;
    req_wdata <= wd;
    @(negedge core_clk);
    for (t = 0; t < 50 && req_ready !== 1'b1; t++) @(negedge core_clk);
    chk(36'(t < 50), 36'h1, "ready wait");
    @(posedge core_clk);
    req_valid <= 1'b0;
    // Next beat data only after the current one is taken
    for (k = 1; wr && k <= n; k++) begin
      @(negedge core_clk);
      for (t = 0; t < 50 && beat_take !== 1'b1; t++) @(negedge core_clk);
      chk(36'(t < 50), 36'h1, "beat wait");
      @(posedge core_clk);
      req_wdata <= wd + k;
    end
    @(negedge core_clk);
    for (t = 0; t < 50 && (cpu_busy !== 1'b0 || mem_busy !== 1'b0); t++) @(negedge core_clk);
    chk(36'(t < 50), 36'h1, "end wait");
    repeat (3) @(posedge core_clk);
  endtask : xfer

  // Store, check the lanes the memory wrote, update the lane model
  task automatic st(input logic by, input logic ls, input logic [2:0] n, input logic [31:0] a,
                    input logic [31:0] wd);
    int k;
    logic [1:0] ln;
    logic [3:0] en;
    wr_q.delete();
    xfer(1'b1, by, ls, n, a, wd);
    ln = bigend ? ~a[1:0] : a[1:0];
    en = (by && ls) ? 4'h1 << ln : 4'hf;
    chk(36'(wr_q.size()), 36'(n), "store count");
    for (k = 0; k < n && wr_q.size() > 0; k++) begin
      chk(wr_q.pop_front(), {en, 32'(a[7:2] + k)}, "store lanes");
      if (by && ls) exp_mem[a[7:2] + k][8 * ln +: 8] = wd[7:0];
      else exp_mem[a[7:2] + k] = wd + k;
    end
  endtask : st

  // Load and compare against the lane model
  task automatic ld(input logic by, input logic ls, input logic [2:0] n, input logic [31:0] a);
    int k;
    logic [1:0] ln;
    logic [31:0] w;
    rd_q.delete();
    rd_e_q.delete();
    xfer(1'b0, by, ls, n, a, 32'h0);
    ln = bigend ? ~a[1:0] : a[1:0];
    chk(36'(rd_q.size()), 36'(n), "load count");
    chk(36'(rd_e_q.size()), 36'(n), "early load count");
    for (k = 0; k < n && rd_q.size() > 0 && rd_e_q.size() > 0; k++) begin
      w = exp_mem[a[7:2] + k];
      w = (by && ls) ? {24'h0, w[8 * ln +: 8]} : w;
      chk({4'h0, rd_q.pop_front()}, {4'h0, w}, "load data");
      chk({4'h0, rd_e_q.pop_front()}, {4'h0, w}, "early load data");
    end
  endtask : ld

  task automatic end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim

  // ********
  // Main sequence
  // ********
  initial begin
    core_clk  = 1'b0;
    srst      = 1'b1;
    bigend    = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_byte  = 1'b0;
    req_ldst  = 1'b0;
    req_beats = 3'h0;
    req_addr  = 32'h0;
    req_wdata = 32'h0;
    error_cnt = 0;
    checks    = 0;
    repeat (10) @(posedge core_clk);
    srst <= 1'b0;
    // Same sequence little-endian, then big-endian
    for (e = 0; e < 2; e++) begin
      bigend <= e[0];
      @(posedge core_clk);
      st(1'b0, 1'b1, 3'h4, 32'h40 + e * 32'h20, 32'h1122_3344);
      ld(1'b0, 1'b1, 3'h4, 32'h40 + e * 32'h20);
      for (o = 0; o < 4; o++) st(1'b1, 1'b1, 3'h1, 32'h40 + e * 32'h20 + o, 32'hdead_be00 + o);
      ld(1'b0, 1'b1, 3'h1, 32'h40 + e * 32'h20);
      for (o = 0; o < 4; o++) ld(1'b1, 1'b1, 3'h1, 32'h40 + e * 32'h20 + o);
      st(1'b1, 1'b0, 3'h1, 32'h45 + e * 32'h20, 32'h5566_7788);
      ld(1'b1, 1'b0, 3'h1, 32'h46 + e * 32'h20);
    end
    // Bytes stored big-endian, read back little-endian by lane
    bigend <= 1'b0;
    @(posedge core_clk);
    for (o = 0; o < 4; o++) ld(1'b1, 1'b1, 3'h1, 32'h60 + o);
    end_sim();
  end

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    #40000;
    error_cnt++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    end_sim();
  end
endmodule : testbench
